// >>> logic/wdg_consts.svh
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH
// ----------------------------------------
// widths and resets
// ----------------------------------------
`define WDG_CNT_W        12
`define WDG_PRE_W        8
`define WDG_CNT_RST      12'h0FFF
`define WDG_PRE_RST      8'h00
`define WDG_CNT_ZERO     12'h0000
`define WDG_CNT_ONE      12'h0001
// ----------------------------------------
// timing
// ----------------------------------------
`define WDG_CLK_HZ       10000000
`define WDG_OSC_HZ       32000
`define WDG_OSC_DIV      ((`WDG_CLK_HZ + `WDG_OSC_HZ - 1) / `WDG_OSC_HZ)
`define WDG_RST_PULSE    8'h10
`endif

// >>> logic/wdg_pkg.sv
`default_nettype none
package wdg_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_FIRE  = 2'b10
    } wdg_state_e;
endpackage
`default_nettype wire

// >>> logic/osc_tick.sv
`include "wdg_consts.svh"
`default_nettype none
// ----------------------------------------
// divider standing in for the slow rc clock
// ----------------------------------------
module osc_tick #(
    parameter int DIV = `WDG_OSC_DIV
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    output logic      tick
);
    logic [15:0] cnt_ff;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= 16'h0000;
            tick   <= 1'b0;
        end else if (cnt_ff == 16'(DIV - 1)) begin
            cnt_ff <= 16'h0000;
            tick   <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
            tick   <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> logic/independent_watchdog.sv
`include "wdg_consts.svh"
`default_nettype none
module independent_watchdog #(
    parameter int                OSC_DIV   = `WDG_OSC_DIV,
    parameter logic [`WDG_PRE_W-1:0] PRE_DIV = 8'hFF,
    parameter logic [7:0]        RST_PULSE = `WDG_RST_PULSE
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  opt_hw_start,
    input  wire logic                  timer_mode,
    input  wire logic                  sw_start,
    input  wire logic                  refresh,
    input  wire logic [`WDG_CNT_W-1:0] reload_val,
    input  wire logic                  low_power,
    input  wire logic                  dbg_halt_en,
    input  wire logic                  core_in_debug,
    output logic                       chip_reset,
    output logic                       timeout,
    output logic                       running,
    output logic [`WDG_CNT_W-1:0]      count
);
    // ----------------------------------------
    // local state
    // ----------------------------------------
    logic                  tick;
    logic [`WDG_PRE_W-1:0] pre_ff;
    logic                  pre_done;
    logic                  halted;
    logic                  expire;
    logic                  bite;
    logic                  lapse;
    logic [7:0]            pulse_ff;
    logic                  hw_ff;
    logic [`WDG_CNT_W-1:0] count_ff;
    logic                  running_ff;
    logic                  timeout_ff;
    logic                  chip_reset_ff;
    wdg_pkg::wdg_state_e   state_ff;

    // ----------------------------------------
    // shared decode
    // ----------------------------------------
    // expiry only on the step out of 1 (to 0, or to reload_val in timer mode); a refresh in the same cycle wins
    function automatic logic expiry_hit(
        input logic                  run,
        input logic                  step,
        input logic                  kick,
        input logic [`WDG_CNT_W-1:0] cnt
    );
        expiry_hit = run & step & ~kick & (cnt == `WDG_CNT_ONE);
    endfunction

    // prescaler wraps at its programmed top value
    function automatic logic pre_wrap(
        input logic [`WDG_PRE_W-1:0] pre,
        input logic [`WDG_PRE_W-1:0] top
    );
        pre_wrap = (pre == top);
    endfunction

    // ----------------------------------------
    // slow tick and prescaler
    // ----------------------------------------
    osc_tick #(.DIV(OSC_DIV)) u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    // low_power deliberately not read: counting never stops in stop/standby
    assign halted   = dbg_halt_en & core_in_debug;
    assign pre_done = tick & pre_wrap(pre_ff, PRE_DIV) & ~halted;
    assign expire   = expiry_hit(state_ff == wdg_pkg::ST_RUN, pre_done, refresh, count_ff);
    assign bite     = expire & ~timer_mode;
    assign lapse    = expire & timer_mode;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_ff <= `WDG_PRE_RST;
        end else if (state_ff != wdg_pkg::ST_RUN || refresh) begin
            pre_ff <= `WDG_PRE_RST;
        end else if (tick && !halted) begin
            if (pre_wrap(pre_ff, PRE_DIV)) begin
                pre_ff <= `WDG_PRE_RST;
            end else begin
                pre_ff <= pre_ff + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // start control
    // ----------------------------------------
    // option level caught one edge after release, never under reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hw_ff <= 1'b0;
        end else begin
            hw_ff <= opt_hw_start;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= wdg_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                wdg_pkg::ST_IDLE: begin
                    if (hw_ff || sw_start) begin
                        state_ff <= wdg_pkg::ST_RUN;
                    end
                end
                wdg_pkg::ST_RUN: begin
                    if (bite) begin
                        state_ff <= wdg_pkg::ST_FIRE;
                    end
                end
                wdg_pkg::ST_FIRE: begin
                    if (pulse_ff == 8'h00) begin
                        state_ff <= wdg_pkg::ST_IDLE;
                    end
                end
                default: state_ff <= wdg_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // down-counter
    // ----------------------------------------
    // idle keeps loading so a start begins from the programmed value
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= `WDG_CNT_RST;
        end else if (state_ff != wdg_pkg::ST_RUN || refresh) begin
            count_ff <= reload_val;
        end else if (pre_done) begin
            if (count_ff == `WDG_CNT_ONE || count_ff == `WDG_CNT_ZERO) begin
                count_ff <= timer_mode ? reload_val : `WDG_CNT_ZERO;
            end else begin
                count_ff <= count_ff - `WDG_CNT_ONE;
            end
        end
    end

    // ----------------------------------------
    // timer mode event
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timeout_ff <= 1'b0;
        end else begin
            timeout_ff <= lapse;
        end
    end

    // ----------------------------------------
    // chip reset pulse
    // ----------------------------------------
    // fixed-length pulse so the reset net sees a clean assertion
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_ff <= 8'h00;
        end else if (bite) begin
            pulse_ff <= RST_PULSE - 8'h01;
        end else if (pulse_ff != 8'h00) begin
            pulse_ff <= pulse_ff - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chip_reset_ff <= 1'b0;
        end else begin
            chip_reset_ff <= bite | (pulse_ff != 8'h00);
        end
    end

    // ----------------------------------------
    // status
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            running_ff <= 1'b0;
        end else begin
            running_ff <= (state_ff == wdg_pkg::ST_RUN);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // every output is a bare flop, no logic after it
    assign count      = count_ff;
    assign running    = running_ff;
    assign timeout    = timeout_ff;
    assign chip_reset = chip_reset_ff;
endmodule
`default_nettype wire

// >>> test/watchdog_chk_asserts.sv
`default_nettype none
module watchdog_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        opt_hw_start,
    input wire logic        timer_mode,
    input wire logic        sw_start,
    input wire logic        refresh,
    input wire logic [11:0] reload_val,
    input wire logic        low_power,
    input wire logic        dbg_halt_en,
    input wire logic        core_in_debug,
    input wire logic        chip_reset,
    input wire logic        timeout,
    input wire logic        running,
    input wire logic [11:0] count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // sixteen cycle reset pulse, then low
    sequence s_hold; chip_reset [*8] ##1 chip_reset [*8] ##1 !chip_reset; endsequence
    property p_dec;
        running && $past(running) && !$past(refresh) && $past(count) != 12'h001
            && $changed(count) |-> count == $past(count) - 12'h001;
    endproperty
    a_dec: assert property (p_dec) else $error("count step");
    property p_ref; running && refresh |=> count == $past(reload_val); endproperty
    a_ref: assert property (p_ref) else $error("reload");
    property p_pulse; $rose(chip_reset) |-> s_hold; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse");
    property p_tmr; timer_mode && $past(timer_mode) |-> !$rose(chip_reset); endproperty
    a_tmr: assert property (p_tmr) else $error("timer reset");
    property p_to; timeout |-> $past(timer_mode) ##1 !timeout; endproperty
    a_to: assert property (p_to) else $error("timeout pulse");
    property p_hw; $fell(sys_rst) && opt_hw_start |-> ##[1:4] running; endproperty
    a_hw: assert property (p_hw) else $error("hw start");
    property p_lp; running && low_power && count > 12'h001 |=> running; endproperty
    a_lp: assert property (p_lp) else $error("low power");
    // two halted cycles, so a registered freeze is allowed one edge
    property p_dbg;
        running && $past(running) && dbg_halt_en && core_in_debug && !$past(refresh)
            && $past(dbg_halt_en && core_in_debug) |-> $stable(count);
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug halt");
endmodule
bind independent_watchdog watchdog_chk u_chk (.*);
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst, opt_hw_start, timer_mode, sw_start, refresh, low_power;
    logic dbg_halt_en, core_in_debug, chip_reset, timeout, running;
    logic [11:0] reload_val, count, v;
    int mismatches, samples_checked, n;
    // short divisors: one decrement per four clocks
    independent_watchdog #(.OSC_DIV(2), .PRE_DIV(8'h01)) u_dut (.*);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic kick(input logic [11:0] r);
        @(posedge clk);
        reload_val <= r;
        refresh <= 1'b1;
        @(posedge clk);
        refresh <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_count;
        for (n = 0; n < 10 && running !== 1'b1; n++) @(negedge clk);
        chk({11'h0, running}, 12'h001);
        kick(12'h0ABC);
        chk(count, 12'h0ABC);
        for (n = 0; n < 20 && count === 12'h0ABC; n++) @(negedge clk);
        chk(count, 12'h0ABB);
        chk({11'h0, n > 1}, 12'h001);
    endtask
    task automatic t_halt;
        @(posedge clk);
        dbg_halt_en <= 1'b1;
        core_in_debug <= 1'b1;
        low_power <= 1'b1;
        repeat (3) @(negedge clk);
        v = count;
        repeat (20) @(negedge clk);
        chk(count, v);
        @(posedge clk);
        core_in_debug <= 1'b0;
        repeat (20) @(negedge clk);
        chk({11'h0, count !== v}, 12'h001);
    endtask
    task automatic t_bite;
        kick(12'h0003);
        for (n = 0; n < 60 && chip_reset !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 40 && chip_reset === 1'b1; n++) @(negedge clk);
        chk(n[11:0], 12'h010);
    endtask
    task automatic t_timer;
        @(posedge clk);
        timer_mode <= 1'b1;
        for (n = 0; n < 40 && running !== 1'b1; n++) @(negedge clk);
        kick(12'h0005);
        for (n = 0; n < 80 && timeout !== 1'b1; n++) @(negedge clk);
        chk({11'h0, timeout}, 12'h001);
        chk(count, 12'h0005);
        repeat (20) @(negedge clk);
        chk({11'h0, chip_reset}, 12'h000);
    endtask
    task automatic t_sw;
        @(posedge clk);
        sys_rst <= 1'b1;
        opt_hw_start <= 1'b0;
        timer_mode <= 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(negedge clk);
        chk({11'h0, running}, 12'h000);
        @(posedge clk);
        sw_start <= 1'b1;
        @(posedge clk);
        sw_start <= 1'b0;
        repeat (3) @(negedge clk);
        chk({11'h0, running}, 12'h001);
    endtask
    initial begin
        {sys_rst, opt_hw_start, reload_val} = {2'b11, 12'h0010};
        {timer_mode, sw_start, refresh, low_power, dbg_halt_en, core_in_debug} = '0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_count();
        t_halt();
        t_bite();
        t_timer();
        t_sw();
        report_and_stop();
    end
    // whole run is a few hundred clocks
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
